// ---- spm_pkg.sv ----
// constants and types for the switch power mode controller
// Behaviour
// - mode 00 normal: clock, transceivers, mac and host interface on
// - mode 01 energy detect: clock, host off; mac and phy on until low power, then rx energy detect only
// - mode 10 soft power down: clock, transceivers, mac, host all off
// - mode 11 power saving: clock, host on; unused receiver portion off
// - per-port bit set to one powers down that port's transceiver
// - hard power-down input low powers down the whole chip
// - hard power-down release issues an internal reset before resuming
// - after reset the mode field holds the normal encoding
// - host access in soft power down wakes to normal with internal reset
// - energy detect: low power after no energy longer than idle delay (never at idle delay 255, where the idle count wraps)
// - energy detect low power: return to normal power once energy seen
package spm_pkg;
	localparam int NUM_PORTS = 5;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ENERGY = 2'h1;
	localparam logic [1:0] MODE_SOFT_PD = 2'h2;
	localparam logic [1:0] MODE_SAVING = 2'h3;
	localparam logic [1:0] MODE_RESET = MODE_NORMAL;
	localparam logic [7:0] IDLE_DELAY_RESET = 8'h00;
	// internal reset pulse length in clock cycles
	localparam logic [3:0] INT_RESET_CYCLES = 4'h8;
	localparam logic [3:0] INT_RESET_ONE = 4'h1;
	localparam logic [7:0] IDLE_ONE = 8'h01;

	typedef enum logic [3:0] {
		SPM_RUN = 4'h1,
		SPM_HARD_PD = 4'h2,
		SPM_INT_RESET = 4'h4,
		SPM_ED_LOW = 4'h8
	} spm_state_e;
endpackage : spm_pkg

// ---- spm_power_ctrl.sv ----
// power mode controller: mode gating, port power-down, hard power-down, wake
module spm_power_ctrl (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hard_powerdown_n,
	input wire logic [1:0] mode_wdata,
	input wire logic mode_we,
	input wire logic [7:0] idle_delay_wdata,
	input wire logic idle_delay_we,
	input wire logic [4:0] port_pd_wdata,
	input wire logic port_pd_we,
	input wire logic host_access,
	input wire logic cable_energy,
	output logic [1:0] mode,
	output logic [7:0] idle_delay,
	output logic [4:0] port_pd,
	output logic clkgen_en,
	output logic host_if_en,
	output logic mac_en,
	output logic [4:0] phy_tx_en,
	output logic [4:0] phy_rx_en,
	output logic [4:0] phy_rx_saving,
	output logic [4:0] phy_energy_det_en,
	output logic ed_low_power,
	output logic chip_pd,
	output logic int_reset
);
	typedef struct packed {
		logic pd_meta;
		logic pd_sync;
		spm_pkg::spm_state_e state;
		logic [1:0] mode;
		logic [7:0] idle_delay;
		logic [7:0] idle_cnt;
		logic [3:0] rst_cnt;
		logic [4:0] port_pd;
		logic clkgen_en;
		logic host_if_en;
		logic mac_en;
		logic [4:0] phy_tx_en;
		logic [4:0] phy_rx_en;
		logic [4:0] phy_rx_saving;
		logic [4:0] phy_energy_det_en;
		logic ed_low_power;
		logic chip_pd;
		logic int_reset;
	} spm_s;

	spm_s cur_ff;
	spm_s nxt_ff;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_ff = cur_ff;
		// first stage is read only by the second
		nxt_ff.pd_meta = hard_powerdown_n;
		nxt_ff.pd_sync = cur_ff.pd_meta;
		unique case (cur_ff.state)
			spm_pkg::SPM_RUN: begin
				if (mode_we) begin
					nxt_ff.mode = mode_wdata;
				end
				if (idle_delay_we) begin
					nxt_ff.idle_delay = idle_delay_wdata;
				end
				if (port_pd_we) begin
					nxt_ff.port_pd = port_pd_wdata;
				end
				if (cur_ff.mode != spm_pkg::MODE_ENERGY || cable_energy) begin
					nxt_ff.idle_cnt = '0;
				end else if (cur_ff.idle_cnt > cur_ff.idle_delay) begin
					nxt_ff.state = spm_pkg::SPM_ED_LOW;
					nxt_ff.idle_cnt = '0;
				end else begin
					nxt_ff.idle_cnt = cur_ff.idle_cnt + spm_pkg::IDLE_ONE;
				end
				// host access wins over a same-cycle register write
				if (cur_ff.mode == spm_pkg::MODE_SOFT_PD && host_access) begin
					nxt_ff.state = spm_pkg::SPM_INT_RESET;
					nxt_ff.rst_cnt = spm_pkg::INT_RESET_CYCLES;
				end
			end
			spm_pkg::SPM_ED_LOW: begin
				if (cable_energy || cur_ff.mode != spm_pkg::MODE_ENERGY) begin
					nxt_ff.state = spm_pkg::SPM_RUN;
				end
			end
			spm_pkg::SPM_HARD_PD: begin
				if (cur_ff.pd_sync) begin
					nxt_ff.state = spm_pkg::SPM_INT_RESET;
					nxt_ff.rst_cnt = spm_pkg::INT_RESET_CYCLES;
				end
			end
			spm_pkg::SPM_INT_RESET: begin
				// every setting returns to its default while reset runs
				nxt_ff.mode = spm_pkg::MODE_RESET;
				nxt_ff.idle_delay = spm_pkg::IDLE_DELAY_RESET;
				nxt_ff.port_pd = '0;
				nxt_ff.idle_cnt = '0;
				nxt_ff.rst_cnt = cur_ff.rst_cnt - spm_pkg::INT_RESET_ONE;
				if (cur_ff.rst_cnt == spm_pkg::INT_RESET_ONE) begin
					nxt_ff.state = spm_pkg::SPM_RUN;
				end
			end
			default: begin
				nxt_ff.state = spm_pkg::SPM_INT_RESET;
				nxt_ff.rst_cnt = spm_pkg::INT_RESET_CYCLES;
			end
		endcase
		if (!cur_ff.pd_sync) begin
			nxt_ff.state = spm_pkg::SPM_HARD_PD;
		end
		// gating decode from next state so outputs stay registered
		nxt_ff.chip_pd = (nxt_ff.state == spm_pkg::SPM_HARD_PD);
		nxt_ff.int_reset = (nxt_ff.state == spm_pkg::SPM_INT_RESET);
		nxt_ff.ed_low_power = (nxt_ff.state == spm_pkg::SPM_ED_LOW);
		nxt_ff.clkgen_en = 1'b0;
		nxt_ff.host_if_en = 1'b0;
		nxt_ff.mac_en = 1'b0;
		nxt_ff.phy_tx_en = '0;
		nxt_ff.phy_rx_en = '0;
		nxt_ff.phy_rx_saving = '0;
		nxt_ff.phy_energy_det_en = '0;
		if (nxt_ff.state == spm_pkg::SPM_ED_LOW) begin
			nxt_ff.phy_energy_det_en = ~nxt_ff.port_pd;
		end else if (nxt_ff.state == spm_pkg::SPM_RUN) begin
			unique case (nxt_ff.mode)
				spm_pkg::MODE_NORMAL: begin
					nxt_ff.clkgen_en = 1'b1;
					nxt_ff.host_if_en = 1'b1;
					nxt_ff.mac_en = 1'b1;
					nxt_ff.phy_tx_en = ~nxt_ff.port_pd;
					nxt_ff.phy_rx_en = ~nxt_ff.port_pd;
				end
				spm_pkg::MODE_ENERGY: begin
					// normal power state of energy detect: phy and mac live
					nxt_ff.mac_en = 1'b1;
					nxt_ff.phy_tx_en = ~nxt_ff.port_pd;
					nxt_ff.phy_rx_en = ~nxt_ff.port_pd;
					nxt_ff.phy_energy_det_en = ~nxt_ff.port_pd;
				end
				spm_pkg::MODE_SOFT_PD: begin
					nxt_ff.clkgen_en = 1'b0;
				end
				spm_pkg::MODE_SAVING: begin
					nxt_ff.clkgen_en = 1'b1;
					nxt_ff.host_if_en = 1'b1;
					nxt_ff.mac_en = 1'b1;
					nxt_ff.phy_tx_en = ~nxt_ff.port_pd;
					nxt_ff.phy_rx_en = ~nxt_ff.port_pd;
					nxt_ff.phy_rx_saving = ~nxt_ff.port_pd;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cur_ff <= '0;
			cur_ff.state <= spm_pkg::SPM_RUN;
			cur_ff.mode <= spm_pkg::MODE_RESET;
			cur_ff.idle_delay <= spm_pkg::IDLE_DELAY_RESET;
			cur_ff.pd_meta <= 1'b1;
			cur_ff.pd_sync <= 1'b1;
			cur_ff.clkgen_en <= 1'b1;
			cur_ff.host_if_en <= 1'b1;
			cur_ff.mac_en <= 1'b1;
			cur_ff.phy_tx_en <= 5'h1F;
			cur_ff.phy_rx_en <= 5'h1F;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign mode = cur_ff.mode;
	assign idle_delay = cur_ff.idle_delay;
	assign port_pd = cur_ff.port_pd;
	assign clkgen_en = cur_ff.clkgen_en;
	assign host_if_en = cur_ff.host_if_en;
	assign mac_en = cur_ff.mac_en;
	assign phy_tx_en = cur_ff.phy_tx_en;
	assign phy_rx_en = cur_ff.phy_rx_en;
	assign phy_rx_saving = cur_ff.phy_rx_saving;
	assign phy_energy_det_en = cur_ff.phy_energy_det_en;
	assign ed_low_power = cur_ff.ed_low_power;
	assign chip_pd = cur_ff.chip_pd;
	assign int_reset = cur_ff.int_reset;

	////////////////////////////////////////////////////////////////////////
	AST_NORMAL_ALL_ON: assert property (
		@(posedge clock) disable iff (!nrst)
		(cur_ff.state == spm_pkg::SPM_RUN && mode == spm_pkg::MODE_NORMAL)
		|-> (clkgen_en && host_if_en && mac_en
		&& phy_tx_en == ~port_pd))
		else $error("normal mode with a block disabled");
	AST_ENERGY_CLK_OFF: assert property (
		@(posedge clock) disable iff (!nrst)
		(mode == spm_pkg::MODE_ENERGY) |-> (!clkgen_en && !host_if_en))
		else $error("energy detect mode with clock or host on");
	AST_SOFT_PD_OFF: assert property (
		@(posedge clock) disable iff (!nrst)
		(mode == spm_pkg::MODE_SOFT_PD) |-> (!clkgen_en && !mac_en
		&& phy_tx_en == 5'h00 && !host_if_en))
		else $error("soft power down with a block enabled");
	AST_SAVING_RX: assert property (
		@(posedge clock) disable iff (!nrst)
		(cur_ff.state == spm_pkg::SPM_RUN && mode == spm_pkg::MODE_SAVING)
		|-> (clkgen_en && host_if_en
		&& phy_rx_saving == ~port_pd))
		else $error("power saving mode gating wrong");
	AST_PORT_PD: assert property (
		@(posedge clock) disable iff (!nrst)
		((port_pd & (phy_tx_en | phy_rx_en)) == 5'h00))
		else $error("powered down port transceiver enabled");
	// two sync stages plus the state register: chip_pd follows a cycle later
	AST_HARD_PD: assert property (
		@(posedge clock) disable iff (!nrst)
		(!hard_powerdown_n [*3]) |=> (chip_pd && !clkgen_en))
		else $error("hard power down not applied");
	// three high samples single out the one edge before int_reset rises
	AST_RELEASE_RESET: assert property (
		@(posedge clock) disable iff (!nrst)
		(chip_pd && hard_powerdown_n && $past(hard_powerdown_n)
		&& $past(hard_powerdown_n, 2)) |=>
		(int_reset [*8]) ##1 !int_reset)
		else $error("no internal reset after power down release");
	AST_WAKE: assert property (
		@(posedge clock) disable iff (!nrst)
		(cur_ff.state == spm_pkg::SPM_RUN && mode == spm_pkg::MODE_SOFT_PD
		&& host_access && cur_ff.pd_sync) |=> ##[1:9]
		(mode == spm_pkg::MODE_NORMAL && clkgen_en))
		else $error("host access did not wake soft power down");
	AST_ED_WAKE: assert property (
		@(posedge clock) disable iff (!nrst)
		(ed_low_power && cable_energy && cur_ff.pd_sync)
		|=> !ed_low_power)
		else $error("energy did not end low power state");
	AST_ED_SLEEP: assert property (
		@(posedge clock) disable iff (!nrst)
		$rose(ed_low_power) |-> ($past(cur_ff.idle_cnt) > idle_delay))
		else $error("low power entered before idle delay");
endmodule : spm_power_ctrl

// ---- tb_spm_power_ctrl.sv ----
// self-checking bench for the switch power mode controller
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic hpd_n = 1'b1;
	logic [1:0] mwd = 2'h0;
	logic mwe = 1'b0;
	logic [7:0] iwd = 8'h00;
	logic iwe = 1'b0;
	logic [4:0] pwd = 5'h00;
	logic pwe = 1'b0;
	logic hacc = 1'b0;
	logic energy = 1'b1;
	logic [1:0] mode;
	logic [7:0] idle_delay;
	logic [4:0] port_pd;
	logic [4:0] tx_en;
	logic [4:0] rx_sav;
	logic [4:0] rx_en;
	logic [4:0] ed_en;
	logic clk_en, host_en, mac_en, ed_low, chip_pd, int_reset;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	int d;
	int p;
	spm_power_ctrl u_spm_power_ctrl (.clock(clock), .nrst(nrst),
		.hard_powerdown_n(hpd_n), .mode_wdata(mwd), .mode_we(mwe),
		.idle_delay_wdata(iwd), .idle_delay_we(iwe),
		.port_pd_wdata(pwd), .port_pd_we(pwe), .host_access(hacc),
		.cable_energy(energy), .mode(mode), .idle_delay(idle_delay),
		.port_pd(port_pd), .clkgen_en(clk_en), .host_if_en(host_en),
		.mac_en(mac_en), .phy_tx_en(tx_en), .phy_rx_en(rx_en),
		.phy_rx_saving(rx_sav), .phy_energy_det_en(ed_en),
		.ed_low_power(ed_low), .chip_pd(chip_pd), .int_reset(int_reset));
	always #25 clock = ~clock;
	// a hang anywhere below ends here, counted as a mismatch
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	task tally_and_finish();
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// lands just after the edge so drives never race the sampling edge
	task step(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : step
	// one strobe pulse, then a free cycle so strobes never retoggle at once
	task wr(input int sel, input logic [7:0] v);
		mwd = v[1:0];
		iwd = v;
		pwd = v[4:0];
		mwe = (sel == 0);
		iwe = (sel == 1);
		pwe = (sel == 2);
		step(1);
		mwe = 1'b0;
		iwe = 1'b0;
		pwe = 1'b0;
		step(1);
	endtask : wr
	task ireset();
		int len;
		len = 0;
		n = 0;
		while (int_reset !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		while (int_reset === 1'b1 && len < 20) begin
			step(1);
			len++;
		end
		chk(8'(len), 8'(spm_pkg::INT_RESET_CYCLES));
		chk(8'(mode), 8'h00);
		chk(8'(port_pd), 8'h00);
		chk(idle_delay, 8'h00);
		chk(8'({chip_pd, clk_en, host_en, mac_en}), 8'h07);
	endtask : ireset
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h7594));
		step(2);
		nrst = 1'b1;
		step(1);
		chk(8'(mode), 8'h00);
		chk(8'({clk_en, host_en, mac_en}), 8'h07);
		chk(8'(tx_en), 8'h1F);
		wr(0, 8'h03);
		chk(8'({clk_en, host_en, mac_en}), 8'h07);
		chk(8'(rx_sav), 8'h1F);
		chk(8'(rx_en), 8'h1F);
		wr(0, 8'h00);
		p = $urandom % 31 + 1;
		wr(2, 8'(p));
		chk(8'(port_pd), 8'(p));
		chk(8'(tx_en), 8'(~p & 31));
		chk(8'(rx_en), 8'(~p & 31));
		d = $urandom % 8 + 2;
		wr(1, 8'(d));
		chk(idle_delay, 8'(d));
		wr(0, 8'h01);
		chk(8'({clk_en, host_en, mac_en}), 8'h01);
		chk(8'(ed_en), 8'(~p & 31));
		energy = 1'b0;
		n = 0;
		while (ed_low !== 1'b1 && n < 40) begin
			step(1);
			n++;
		end
		chk(8'(n >= d && n <= d + 4), 8'h01);
		chk(8'(ed_en), 8'(~p & 31));
		chk(8'({tx_en, mac_en, clk_en}), 8'h00);
		// writes are refused while asleep
		wr(0, 8'h00);
		chk(8'(mode), 8'h01);
		energy = 1'b1;
		step(1);
		chk(8'(ed_low), 8'h00);
		wr(0, 8'h00);
		chk(8'(mode), 8'h00);
		wr(0, 8'h02);
		chk(8'({clk_en, host_en, mac_en}), 8'h00);
		chk(8'(tx_en), 8'h00);
		chk(8'(rx_en | ed_en), 8'h00);
		hacc = 1'b1;
		step(1);
		hacc = 1'b0;
		ireset();
		wr(0, 8'h03);
		hpd_n = 1'b0;
		n = 0;
		while (chip_pd !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		chk(8'(n), 8'h03);
		wr(0, 8'h00);
		chk(8'({chip_pd, mode}), 8'h07);
		chk(8'({clk_en, host_en, mac_en}), 8'h00);
		chk(8'(tx_en | rx_en), 8'h00);
		hpd_n = 1'b1;
		ireset();
		chk(8'(n), 8'h03);
		tally_and_finish();
	end
endmodule : tb_top
